// ### common/dcs_defs.vh
// Purpose: Shared constants for the dual converter sequencer
// Assumes: Included by the design files by bare name
// Notes:   Register indexes are word indexes; byte address is four times the index
`ifndef DCS_DEFS_VH
`define DCS_DEFS_VH

// ==========================================================
// Register word indexes
`define DCS_IDX_CTRL_A 15'h7032
`define DCS_IDX_CTRL_B 15'h7034
`define DCS_IDX_FIFO_ONE 15'h7036
`define DCS_IDX_FIFO_TWO 15'h7038

// ==========================================================
// Control A field positions
`define DCS_A_SUSP_SOFT 15
`define DCS_A_SUSP_FREE 14
`define DCS_A_IMM_START 13
`define DCS_A_EN_ONE 12
`define DCS_A_EN_TWO 11
`define DCS_A_CONT 10
`define DCS_A_INT_EN 9
`define DCS_A_FLAG 8
`define DCS_A_BUSY 7
`define DCS_A_CH_TWO_HI 6
`define DCS_A_CH_TWO_LO 4
`define DCS_A_CH_ONE_HI 3
`define DCS_A_CH_ONE_LO 1
`define DCS_A_SOC 0

// ==========================================================
// Control B field positions
`define DCS_B_EV_MASK 10
`define DCS_B_EXT_MASK 9
`define DCS_B_ST_ONE_HI 7
`define DCS_B_ST_ONE_LO 6
`define DCS_B_ST_TWO_HI 4
`define DCS_B_ST_TWO_LO 3
`define DCS_B_PSC_HI 2
`define DCS_B_PSC_LO 0

// ==========================================================
// Reset values and timing counts
`define DCS_RST_CTRL_A 16'h0000
`define DCS_RST_CTRL_B 16'h0000
`define DCS_RST_RESULT 10'h000
`define DCS_SAMPLE_TICKS 3'h1
`define DCS_CONVERT_TICKS 3'h5
`define DCS_TOTAL_TICKS 3'h6

`endif

// ### verilog/dcs_result_fifo.v
// Purpose: Two-entry result store for one converter unit
// Assumes: Push and pop are one-cycle pulses in the system clock
// Notes:   A push into a full store drops the oldest entry and marks overflow
`timescale 1ns/1ns
`include "dcs_defs.vh"

module dcs_result_fifo
(
   // Clock and reset
   input wire clk,
   input wire nrst,
   // Write side
   input wire push,
   input wire [9:0] push_data,
   // Read side
   input wire pop,
   output wire [9:0] head,
   output wire [1:0] status
);

   reg [9:0] slot0_q;
   reg [9:0] slot1_q;
   reg [1:0] count_q;
   reg ovf_q;

   assign head = slot0_q;
   // Overflow outranks the count until the next read [RULE18]
   assign status = ovf_q ? 2'b11 : count_q;

   // ==========================================================
   // Storage
   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         slot0_q <= `DCS_RST_RESULT;
         slot1_q <= `DCS_RST_RESULT;
         count_q <= 2'b00;
         ovf_q <= 1'b0;
      end
      else if (push && pop && count_q != 2'b00)
      begin
         if (count_q == 2'b01)
            slot0_q <= push_data;
         else
         begin
            slot0_q <= slot1_q;
            slot1_q <= push_data;
         end
         ovf_q <= 1'b0;
      end
      else if (push)
      begin
         if (count_q == 2'b00)
         begin
            slot0_q <= push_data;
            count_q <= 2'b01;
         end
         else if (count_q == 2'b01)
         begin
            slot1_q <= push_data;
            count_q <= 2'b10;
         end
         else
         begin
            // Full: oldest lost, newest kept [RULE8] [RULE9]
            slot0_q <= slot1_q;
            slot1_q <= push_data;
            ovf_q <= 1'b1;
         end
      end
      else if (pop && count_q != 2'b00)
      begin
         slot0_q <= slot1_q;
         count_q <= count_q - 2'b01;
         ovf_q <= 1'b0;
      end
   end

endmodule // dcs_result_fifo

// ### verilog/dcs_top.v
// Purpose: Sequencer and register file of a dual 10-bit converter
// Assumes: Analog core delivers both results at the end of conversion
// Notes:   Avalon-MM slave; one wait state on every access
//
// Notes on behaviour
// RULE1: Each unit picks one of eight inputs
// RULE2: Both units sample and convert together
// RULE3: Single and continuous conversion modes
// RULE4: Start by software, pin edge, or events
// RULE5: Shadowed writes never disturb running conversion
// RULE6: Shadow loads into active at conversion end
// RULE7: Flag set each end; request if enabled
// RULE8: Two-deep result store per unit
// RULE9: Third unread result drops the oldest
// RULE10: One sample tick plus five convert ticks
// RULE11: Prescale code selects divide 4 to 32
// RULE12: Software keeps conversion at least six microseconds
// RULE13: Result is 10-bit unsigned code
// RULE14: Four registers decoded, control then results
// RULE15: Inputs 0-7 unit one, 8-15 two
// RULE16: Inputs 0,1,8,9 may be digital pins
// RULE17: Channel code maps to unit input order
// RULE18: Store status empty, one, two, overflow
// RULE19: Writing one clears flag; zero ignored
// RULE20: No start while both units disabled
// RULE21: Continuous mode restarts at once after completion
`timescale 1ns/1ns
`include "dcs_defs.vh"

module dcs_top
(
   // Clock and reset
   input wire clk,
   input wire nrst,
   // Avalon-MM slave
   input wire [16:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   input wire [3:0] avs_byteenable,
   output reg [31:0] avs_readdata,
   output reg avs_waitrequest,
   // Start sources
   input wire ext_start_pin,
   input wire ev_timer_start,
   input wire ev_capture_start,
   // Analog core
   input wire [9:0] core_result_one,
   input wire [9:0] core_result_two,
   input wire [3:0] digital_pin_select,
   output reg [3:0] unit_one_input_q,
   output reg [3:0] unit_two_input_q,
   output reg sample_one_q,
   output reg sample_two_q,
   output reg [15:0] analog_input_enable_q,
   // Status
   output reg conversion_request_q,
   output reg busy_q
);

   localparam ST_IDLE = 1'b0;
   localparam ST_RUN = 1'b1;

   // ==========================================================
   // Declarations
   reg state_q;
   reg [2:0] tick_cnt_q;
   reg [4:0] div_cnt_q;
   reg tick_q;
   reg [15:0] sh_a_q;
   reg [15:0] act_a_q;
   reg [15:0] sh_b_q;
   reg [15:0] act_b_q;
   reg flag_q;
   reg ext_prev_q;
   reg imm_start;
   wire [14:0] word_idx;
   wire bus_go;
   wire wr_a;
   wire wr_b;
   wire [15:0] wmask;
   wire [15:0] a_written;
   wire [15:0] b_written;
   wire [15:0] sh_a_d;
   wire [15:0] sh_b_d;
   wire trig;
   wire start;
   wire done;
   wire restart;
   wire pop_one;
   wire pop_two;
   wire [9:0] head_one;
   wire [9:0] head_two;
   wire [1:0] stat_one;
   wire [1:0] stat_two;
   reg [4:0] div_last;
   reg [15:0] rd_mux;

   // ==========================================================
   // Bus decode
   assign word_idx = avs_address[16:2];
   // A transfer completes on the edge where waitrequest is seen low
   assign bus_go = (avs_read || avs_write) && !avs_waitrequest;
   assign wr_a = bus_go && avs_write && word_idx == `DCS_IDX_CTRL_A; // [RULE14]
   assign wr_b = bus_go && avs_write && word_idx == `DCS_IDX_CTRL_B; // [RULE14]
   assign pop_one = bus_go && avs_read && word_idx == `DCS_IDX_FIFO_ONE; // [RULE14]
   assign pop_two = bus_go && avs_read && word_idx == `DCS_IDX_FIFO_TWO; // [RULE14]
   assign wmask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
   assign a_written = (avs_writedata[15:0] & wmask) | (sh_a_q & ~wmask);
   assign b_written = (avs_writedata[15:0] & wmask) | (sh_b_q & ~wmask);
   // Writes only touch the shadow copy [RULE5]
   assign sh_a_d = wr_a ? a_written : sh_a_q;
   assign sh_b_d = wr_b ? b_written : sh_b_q;

   always @*
   begin
      rd_mux = 16'h0000;
      case (word_idx)
         `DCS_IDX_CTRL_A:
            rd_mux = {sh_a_q[15:14], 1'b0, sh_a_q[12:9], flag_q, busy_q, sh_a_q[6:0]};
         `DCS_IDX_CTRL_B:
            rd_mux = {5'h00, sh_b_q[10:9], 1'b0, stat_one, 1'b0, stat_two, sh_b_q[2:0]};
         `DCS_IDX_FIFO_ONE:
            rd_mux = {6'h00, head_one};
         `DCS_IDX_FIFO_TWO:
            rd_mux = {6'h00, head_two};
         default:
            rd_mux = 16'h0000;
      endcase
   end

   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h0000_0000;
      end
      else if ((avs_read || avs_write) && avs_waitrequest)
      begin
         avs_waitrequest <= 1'b0;
         avs_readdata <= {16'h0000, rd_mux};
      end
      else
         avs_waitrequest <= 1'b1;
   end

   // ==========================================================
   // Prescaler
   always @*
   begin
      case (act_b_q[`DCS_B_PSC_HI:`DCS_B_PSC_LO]) // [RULE11]
         3'b000: div_last = 5'd3;
         3'b001: div_last = 5'd5;
         3'b010: div_last = 5'd7;
         3'b011: div_last = 5'd9;
         3'b100: div_last = 5'd11;
         3'b101: div_last = 5'd15;
         3'b110: div_last = 5'd19;
         default: div_last = 5'd31;
      endcase
   end

   // Divider restarts at each start so the sample tick is full length
   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         div_cnt_q <= 5'd0;
         tick_q <= 1'b0;
      end
      else if (start || state_q == ST_IDLE)
      begin
         div_cnt_q <= 5'd0;
         tick_q <= 1'b0;
      end
      else if (div_cnt_q >= div_last)
      begin
         div_cnt_q <= 5'd0;
         tick_q <= 1'b1; // [RULE11]
      end
      else
      begin
         div_cnt_q <= div_cnt_q + 5'd1;
         tick_q <= 1'b0;
      end
   end

   // ==========================================================
   // Start sources
   always @*
   begin
      imm_start = wr_a && avs_byteenable[1] && avs_writedata[`DCS_A_IMM_START];
   end

   // Masks and enables come from the shadow, which becomes active at start
   assign trig = sh_a_q[`DCS_A_SOC] || imm_start
      || (sh_b_q[`DCS_B_EXT_MASK] && ext_start_pin && !ext_prev_q)
      || (sh_b_q[`DCS_B_EV_MASK] && (ev_timer_start || ev_capture_start)); // [RULE4]
   assign start = state_q == ST_IDLE && trig
      && (sh_a_q[`DCS_A_EN_ONE] || sh_a_q[`DCS_A_EN_TWO]); // [RULE20]
   assign done = state_q == ST_RUN && tick_q && tick_cnt_q == `DCS_TOTAL_TICKS - 3'h1; // [RULE10]
   assign restart = (sh_a_q[`DCS_A_CONT] || sh_a_q[`DCS_A_SOC])
      && (sh_a_q[`DCS_A_EN_ONE] || sh_a_q[`DCS_A_EN_TWO]); // [RULE21] [RULE20]

   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         ext_prev_q <= 1'b0;
      else
         ext_prev_q <= ext_start_pin;
   end

   // ==========================================================
   // Sequencer
   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         state_q <= ST_IDLE;
         tick_cnt_q <= 3'h0;
         busy_q <= 1'b0;
      end
      else
      begin
         case (state_q)
            ST_IDLE:
               if (start)
               begin
                  state_q <= ST_RUN;
                  tick_cnt_q <= 3'h0;
                  busy_q <= 1'b1;
               end
            ST_RUN:
               if (done)
               begin
                  tick_cnt_q <= 3'h0;
                  // Single mode stops unless a start is pending; continuous goes on with new config while a unit stays enabled
                  if (!restart)
                  begin
                     state_q <= ST_IDLE; // [RULE3]
                     busy_q <= 1'b0;
                  end
               end
               else if (tick_q)
                  tick_cnt_q <= tick_cnt_q + 3'h1;
            default:
            begin
               state_q <= ST_IDLE;
               busy_q <= 1'b0;
            end
         endcase
      end
   end

   // ==========================================================
   // Shadow and active control
   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         sh_a_q <= `DCS_RST_CTRL_A;
         sh_b_q <= `DCS_RST_CTRL_B;
         act_a_q <= `DCS_RST_CTRL_A;
         act_b_q <= `DCS_RST_CTRL_B;
      end
      else
      begin
         sh_a_q <= sh_a_d;
         sh_b_q <= sh_b_d;
         sh_a_q[`DCS_A_IMM_START] <= 1'b0;
         sh_a_q[`DCS_A_FLAG] <= 1'b0;
         sh_a_q[`DCS_A_BUSY] <= 1'b0;
         // A pending start is consumed by the conversion it launches
         if (start || (done && restart))
            sh_a_q[`DCS_A_SOC] <= wr_a && avs_writedata[`DCS_A_SOC];
         // Active follows the shadow only between conversions [RULE5] [RULE6]
         if (start || done)
         begin
            act_a_q <= sh_a_q; // [RULE6]
            act_b_q <= sh_b_q;
         end
         else if (state_q == ST_IDLE)
            act_b_q[`DCS_B_PSC_HI:`DCS_B_PSC_LO] <= sh_b_q[`DCS_B_PSC_HI:`DCS_B_PSC_LO];
      end
   end

   // ==========================================================
   // Flag and request
   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         flag_q <= 1'b0;
         conversion_request_q <= 1'b0;
      end
      else
      begin
         // Set wins over a same-cycle clear
         if (done)
            flag_q <= 1'b1; // [RULE7]
         else if (wr_a && avs_byteenable[1] && avs_writedata[`DCS_A_FLAG])
            flag_q <= 1'b0; // [RULE19]
         conversion_request_q <= (flag_q || done) && act_a_q[`DCS_A_INT_EN]; // [RULE7]
      end
   end

   // ==========================================================
   // Analog core steering
   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         unit_one_input_q <= 4'h0;
         unit_two_input_q <= 4'h8;
         sample_one_q <= 1'b0;
         sample_two_q <= 1'b0;
         analog_input_enable_q <= 16'hFFFF;
      end
      else
      begin
         // Channel code counts up through the unit's own bank [RULE1] [RULE17] [RULE15]
         unit_one_input_q <= {1'b0, act_a_q[`DCS_A_CH_ONE_HI:`DCS_A_CH_ONE_LO]};
         unit_two_input_q <= {1'b1, act_a_q[`DCS_A_CH_TWO_HI:`DCS_A_CH_TWO_LO]};
         // Both units share one sample window [RULE2] [RULE10]
         sample_one_q <= state_q == ST_RUN && tick_cnt_q < `DCS_SAMPLE_TICKS
            && act_a_q[`DCS_A_EN_ONE];
         sample_two_q <= state_q == ST_RUN && tick_cnt_q < `DCS_SAMPLE_TICKS
            && act_a_q[`DCS_A_EN_TWO];
         analog_input_enable_q <= {6'h3F, ~digital_pin_select[3:2], 6'h3F,
            ~digital_pin_select[1:0]}; // [RULE16]
      end
   end

   // ==========================================================
   // Result stores; a disabled unit leaves its store alone
   dcs_result_fifo u_fifo_one
   (
      .clk(clk),
      .nrst(nrst),
      .push(done && act_a_q[`DCS_A_EN_ONE]), // [RULE8] [RULE13]
      .push_data(core_result_one),
      .pop(pop_one),
      .head(head_one),
      .status(stat_one)
   );

   dcs_result_fifo u_fifo_two
   (
      .clk(clk),
      .nrst(nrst),
      .push(done && act_a_q[`DCS_A_EN_TWO]), // [RULE8] [RULE13]
      .push_data(core_result_two),
      .pop(pop_two),
      .head(head_two),
      .status(stat_two)
   );

endmodule // dcs_top

// ### verification/dcs_checker.sv
// Purpose: Port-level assertions for the converter sequencer
// Assumes: One clock domain, asynchronous active-low reset
// Notes:   Bound to dcs_top below the module
`timescale 1ns/1ns

module dcs_checker
(
   // Clock and reset
   input logic clk,
   input logic nrst,
   // Register bus
   input logic avs_read,
   input logic avs_write,
   input logic [31:0] avs_readdata,
   input logic avs_waitrequest,
   // Converter side
   input logic [3:0] digital_pin_select,
   input logic [3:0] unit_one_input_q,
   input logic [3:0] unit_two_input_q,
   input logic sample_one_q,
   input logic sample_two_q,
   input logic [15:0] analog_input_enable_q,
   input logic busy_q
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   // ======================================
   // Bus handshake
   sequence s_req_open;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   sequence s_one_ack;
      !avs_waitrequest ##1 avs_waitrequest;
   endsequence
   property p_answer;
      s_req_open |=> s_one_ack;
   endproperty
   a_answer: assert property (p_answer)
      else $error("bus answer late or held too long");
   property p_idle_wait;
      !avs_read && !avs_write |=> avs_waitrequest;
   endproperty
   a_idle_wait: assert property (p_idle_wait)
      else $error("waitrequest low without a request");
   property p_upper_zero;
      avs_readdata[31:16] == 16'h0000;
   endproperty
   a_upper_zero: assert property (p_upper_zero)
      else $error("read data upper half not zero");

   // ======================================
   // Converter side
   property p_sel_one;
      unit_one_input_q[3] == 1'b0;
   endproperty
   a_sel_one: assert property (p_sel_one)
      else $error("unit one picked an input outside 0 to 7");
   property p_sel_two;
      unit_two_input_q[3] == 1'b1;
   endproperty
   a_sel_two: assert property (p_sel_two)
      else $error("unit two picked an input outside 8 to 15");
   // The select seen during reset is not what the register loads from afterwards
   property p_pin_en;
      $past(nrst) |-> analog_input_enable_q == ~{6'h00, $past(digital_pin_select[3:2]),
         6'h00, $past(digital_pin_select[1:0])};
   endproperty
   a_pin_en: assert property (p_pin_en)
      else $error("analog enable does not follow digital select");
   // Smallest divide ratio is four, so a sample tick spans four clocks at least
   property p_sample_len;
      $rose(sample_one_q) |-> sample_one_q [*4];
   endproperty
   a_sample_len: assert property (p_sample_len)
      else $error("sample tick shorter than one prescaled cycle");
   property p_sample_busy;
      sample_one_q || sample_two_q |-> busy_q;
   endproperty
   a_sample_busy: assert property (p_sample_busy)
      else $error("sampling outside a conversion");
endmodule // dcs_checker

bind dcs_top dcs_checker u_dcs_checker
(
   .clk(clk),
   .nrst(nrst),
   .avs_read(avs_read),
   .avs_write(avs_write),
   .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest),
   .digital_pin_select(digital_pin_select),
   .unit_one_input_q(unit_one_input_q),
   .unit_two_input_q(unit_two_input_q),
   .sample_one_q(sample_one_q),
   .sample_two_q(sample_two_q),
   .analog_input_enable_q(analog_input_enable_q),
   .busy_q(busy_q)
);

// ### verification/dcs_core_model.sv
// Purpose: Behavioural analog core for the sequencer bench
// Assumes: Result depends only on the selected input
// Notes:   Input number in the top bits makes a wrong mux choice visible
`timescale 1ns/1ns

module dcs_core_model
(
   // Input selects
   input wire logic [3:0] sel_one,
   input wire logic [3:0] sel_two,
   // Results
   output logic [9:0] res_one,
   output logic [9:0] res_two
);
   assign res_one = {sel_one, 6'h15};
   assign res_two = {sel_two, 6'h15};
endmodule // dcs_core_model

// ### verification/dcs_top_tb_top.sv
// Purpose: Self-checking bench for the converter sequencer
// Assumes: Avalon master with one request in flight
// Notes:   Table rows first, then hand-written sequences
`timescale 1ns/1ns
`include "dcs_defs.vh"

module dcs_top_tb_top;
   logic clk, nrst, avs_read, avs_write, avs_waitrequest;
   logic [16:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata;
   logic [3:0] avs_byteenable, digital_pin_select, unit_one_input_q, unit_two_input_q;
   logic ext_start_pin, ev_timer_start, ev_capture_start, sample_one_q, sample_two_q;
   logic [9:0] core_result_one, core_result_two;
   logic [15:0] analog_input_enable_q;
   logic conversion_request_q, busy_q;
   int err_count = 0;
   int checked = 0;
   // At this clock no ratio reaches the six-microsecond conversion minimum; the bench
   // only checks sequencing, so short conversions are run on purpose
   localparam int ratio [0:7] = '{4, 6, 8, 10, 12, 16, 20, 32};
   // Row: write flag, word index, write data, expected read data
   localparam logic [47:0] rows [0:9] = '{
      {1'b0, `DCS_IDX_CTRL_A, 16'h0000, 16'h0000},
      {1'b0, `DCS_IDX_CTRL_B, 16'h0000, 16'h0000},
      {1'b0, `DCS_IDX_FIFO_ONE, 16'h0000, 16'h0000},
      {1'b0, `DCS_IDX_FIFO_TWO, 16'h0000, 16'h0000},
      {1'b1, `DCS_IDX_CTRL_B, 16'hFFFF, 16'h0000},
      {1'b0, `DCS_IDX_CTRL_B, 16'h0000, 16'h0607},
      {1'b1, 15'h7033, 16'hFFFF, 16'h0000},
      {1'b0, 15'h7033, 16'h0000, 16'h0000},
      {1'b1, `DCS_IDX_CTRL_A, 16'h0076, 16'h0000},
      {1'b0, `DCS_IDX_CTRL_A, 16'h0000, 16'h0076}};

   dcs_top u_dcs_top (.clk(clk), .nrst(nrst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .ext_start_pin(ext_start_pin),
      .ev_timer_start(ev_timer_start), .ev_capture_start(ev_capture_start),
      .core_result_one(core_result_one), .core_result_two(core_result_two),
      .digital_pin_select(digital_pin_select), .unit_one_input_q(unit_one_input_q),
      .unit_two_input_q(unit_two_input_q), .sample_one_q(sample_one_q),
      .sample_two_q(sample_two_q), .analog_input_enable_q(analog_input_enable_q),
      .conversion_request_q(conversion_request_q), .busy_q(busy_q));
   dcs_core_model u_dcs_core_model (.sel_one(unit_one_input_q),
      .sel_two(unit_two_input_q), .res_one(core_result_one), .res_two(core_result_two));

   task automatic end_of_test();
      if (err_count == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic check(input string nm, input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp)
      begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // One request in flight; the extra edge at the end keeps calls apart
   task automatic bus(input logic we, input logic [14:0] idx, input logic [15:0] wd,
      output logic [15:0] rd);
      int n;
      avs_address <= {idx, 2'b00};
      avs_write <= we;
      avs_read <= ~we;
      avs_writedata <= {16'h0000, wd};
      @(posedge clk);
      for (n = 0; avs_waitrequest !== 1'b0 && n < 50; n++) @(posedge clk);
      // A slave that never answers counts against the run
      if (avs_waitrequest !== 1'b0)
         err_count++;
      rd = avs_readdata[15:0];
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wr(input logic [14:0] idx, input logic [15:0] wd);
      logic [15:0] d;
      bus(1'b1, idx, wd, d);
   endtask

   task automatic rdc(input string nm, input logic [14:0] idx, input logic [15:0] exp);
      logic [15:0] d;
      bus(1'b0, idx, 16'h0000, d);
      check(nm, d, exp);
   endtask

   task automatic conv(output int n);
      for (n = 0; busy_q !== 1'b1 && n < 400; n++) @(posedge clk);
      for (; busy_q !== 1'b0 && n < 400; n++) @(posedge clk);
   endtask

   function automatic logic [15:0] res(input int ch);
      return {6'h00, ch[3:0], 6'h15};
   endfunction

   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   initial
   begin
      repeat (20000) @(posedge clk);
      err_count++;
      end_of_test();
   end

   initial
   begin
      logic [15:0] d;
      int n;
      nrst = 1'b0;
      {avs_read, avs_write, avs_address, avs_writedata} = '0;
      avs_byteenable = 4'hF;
      {ext_start_pin, ev_timer_start, ev_capture_start} = 3'h0;
      digital_pin_select = 4'h0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      foreach (rows[i])
      begin
         bus(rows[i][47], rows[i][46:32], rows[i][31:16], d);
         if (!rows[i][47])
            check("row", d, rows[i][15:0]);
      end
      // Each pass uses a new channel, so the store contents show which entries survive
      for (int i = 0; i < 8; i++)
      begin
         wr(`DCS_IDX_CTRL_B, {13'h0000, i[2:0]});
         wr(`DCS_IDX_CTRL_A, {9'h034, 3'(7 - i), i[2:0], 1'b1});
         conv(n);
         check("conv_len", 16'(n >= 6 * ratio[i] - 2 && n <= 7 * ratio[i] + 8), 16'h0001);
         check("sel_one", {12'h000, unit_one_input_q}, 16'(i));
         check("sel_two", {12'h000, unit_two_input_q}, 16'(15 - i));
      end
      check("request", {15'h0000, conversion_request_q}, 16'h0001);
      rdc("status_ovf", `DCS_IDX_CTRL_B, 16'h00DF);
      rdc("fifo1_a", `DCS_IDX_FIFO_ONE, res(6));
      rdc("status_pop", `DCS_IDX_CTRL_B, 16'h005F);
      rdc("fifo1_b", `DCS_IDX_FIFO_ONE, res(7));
      rdc("fifo2_a", `DCS_IDX_FIFO_TWO, res(9));
      rdc("fifo2_b", `DCS_IDX_FIFO_TWO, res(8));
      rdc("status_empty", `DCS_IDX_CTRL_B, 16'h0007);
      wr(`DCS_IDX_CTRL_A, 16'h0200);
      rdc("flag_keep", `DCS_IDX_CTRL_A, 16'h0300);
      wr(`DCS_IDX_CTRL_A, 16'h0300);
      rdc("flag_clear", `DCS_IDX_CTRL_A, 16'h0200);
      check("request_off", {15'h0000, conversion_request_q}, 16'h0000);
      wr(`DCS_IDX_CTRL_A, 16'h0001);
      repeat (40) @(posedge clk);
      check("no_unit", {15'h0000, busy_q}, 16'h0000);
      wr(`DCS_IDX_CTRL_A, 16'h0000);
      wr(`DCS_IDX_CTRL_B, 16'h0600);
      wr(`DCS_IDX_CTRL_A, 16'h1800);
      for (int s = 0; s < 3; s++)
      begin
         {ev_capture_start, ev_timer_start, ext_start_pin} <= 3'h1 << s;
         @(posedge clk);
         {ev_capture_start, ev_timer_start, ext_start_pin} <= 3'h0;
         conv(n);
         check("source", 16'(n < 100), 16'h0001);
      end
      // Continuous run: a channel change mid-conversion waits for the boundary
      wr(`DCS_IDX_CTRL_A, 16'h1C03);
      for (n = 0; busy_q !== 1'b1 && n < 400; n++) @(posedge clk);
      wr(`DCS_IDX_CTRL_A, 16'h1C08);
      check("hold", {12'h000, unit_one_input_q}, 16'h0001);
      for (n = 0; unit_one_input_q !== 4'h4 && n < 400; n++) @(posedge clk);
      check("load", 16'(n >= 8 && n < 60), 16'h0001);
      check("restart", {15'h0000, busy_q}, 16'h0001);
      wr(`DCS_IDX_CTRL_A, 16'h1800);
      conv(n);
      check("stop", 16'(n < 80), 16'h0001);
      digital_pin_select <= 4'h5;
      repeat (2) @(posedge clk);
      check("pins", analog_input_enable_q, 16'hFEFE);
      // Immediate start launches on the write itself, with the enables already set
      wr(`DCS_IDX_CTRL_A, 16'h3800);
      conv(n);
      check("imm", 16'(n >= 20 && n < 40), 16'h0001);
      // Reset in mid-conversion must drop the run; busy, request, waitrequest, unit two select, pin enables and both control registers return to reset values
      wr(`DCS_IDX_CTRL_A, 16'h3A00);
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      check("rst_busy", {15'h0000, busy_q}, 16'h0000);
      check("rst_req", {15'h0000, conversion_request_q}, 16'h0000);
      check("rst_wait", {15'h0000, avs_waitrequest}, 16'h0001);
      check("rst_sel_two", {12'h000, unit_two_input_q}, 16'h0008);
      check("rst_pins", analog_input_enable_q, 16'hFFFF);
      nrst <= 1'b1;
      @(posedge clk);
      rdc("rst_ctrl_a", `DCS_IDX_CTRL_A, 16'h0000);
      rdc("rst_ctrl_b", `DCS_IDX_CTRL_B, 16'h0000);
      end_of_test();
   end
endmodule // dcs_top_tb_top
